// *** core/async_timer2_sync.sv ***
// Second 8-bit timer with an optional asynchronous oscillator clock,
// per-register holding registers, update-busy flags, flag
// synchronisation, power-save wake-up and APB register access.
// Assumes an APB master on pclk and sleep levels from the core on pclk.
//
// The address map and the APB interface to the registers are this design's own decisions.
`include "timer2_defs.svh"

// Contract
// R1: CPU writes to count/compare/control land in holding, copied after two osc edges.
// R2: Each of the three registers has its own holding register.
// R3: Software must not rewrite a register while its transfer is pending.
// R4: Pending count or compare write suppresses compare matching.
// R5: After wake, interrupt logic needs one osc cycle before it rearms.
// R6: Software writes a register and waits busy clear before power-save.
// R7: Software follows the ordered sequence when switching clock source.
// R8: Switching clock source may corrupt count, compare and control.
// R9: Async mode keeps the oscillator running except in power-down.
// R10: Software waits one second after power-up before using async timer.
// R11: Timer register contents are undefined after power-down wake.
// R12: Wake-up begins on the timer clock cycle after the condition.
// R13: After timer wake the CPU stalls four cycles before servicing.
// R14: Async flag transfer takes three pclk cycles plus one osc cycle.
// R15: Compare output is driven on timer ticks, not resynchronised.
// R16: Async register write sets busy; transfer completion clears it.
// R17: Async select clocks from the oscillator pin, else system clock.
// R18: Count reads live value; compare and control read holding register.
module async_timer2_sync #(
    parameter int PRESCALE_W = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_osc_input,
    input wire logic power_save,
    input wire logic power_down,
    output logic osc_enable,
    output logic compare_out,
    output logic irq,
    output logic timer_wake,
    output logic cpu_stall
);

    // ------------------------------------------------------------------
    // Oscillator edge detection
    // ------------------------------------------------------------------
    logic osc_rise_raw;
    logic osc_rise;

    osc_edge_sync u_osc_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(timer_osc_input),
        .rise(osc_rise_raw)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic async_clock_select_r;
    logic [7:0] timer_live_count_r;
    logic [7:0] hold_r [3];
    logic [7:0] dest_r [3];
    logic [2:0] busy_r;
    logic [2:0] edge_cnt_r;
    logic [1:0] irq_flag_r;
    logic [1:0] irq_en_r;
    logic [1:0] ev_pend_r;
    logic [1:0] ev_stage_r [`FLAG_SYNC_PCLK];
    logic [PRESCALE_W-1:0] pre_r;
    logic armed_r;
    logic [2:0] stall_cnt_r;
    timer2_pkg::wake_state_t wake_r;
    timer2_pkg::wake_state_t wake_nxt;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic compare_out_r;
    logic irq_r;
    logic osc_enable_r;
    logic timer_wake_r;
    logic cpu_stall_r;

    // Index 0 control, 1 compare, 2 count: matches the busy bit order.
    localparam int IX_CTL = 0;
    localparam int IX_CMP = 1;
    localparam int IX_CNT = 2;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic presc_hit(input logic [2:0] cs,
                                       input logic [PRESCALE_W-1:0] pre);
        logic hit;
        hit = 1'b0;
        case (cs)
            3'h1: hit = 1'b1;
            3'h2: hit = (pre[2:0] == 3'h7);
            3'h3: hit = (pre[4:0] == 5'h1f);
            3'h4: hit = (pre[5:0] == 6'h3f);
            3'h5: hit = (pre[6:0] == 7'h7f);
            3'h6: hit = (pre[7:0] == 8'hff);
            3'h7: hit = (pre[9:0] == 10'h3ff);
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic [31:0] byte_word(input logic [7:0] b);
        return {24'h000000, b};
    endfunction

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire bus_take = psel & penable & pready_r;
    wire bus_wr = bus_take & pwrite;
    wire hit_cnt = (paddr == `OFS_LIVE_COUNT);
    wire hit_cmp = (paddr == `OFS_COMPARE);
    wire hit_ctl = (paddr == `OFS_CONTROL);
    wire hit_ast = (paddr == `OFS_ASYNC_STATUS);
    wire hit_flg = (paddr == `OFS_IRQ_FLAG);
    wire hit_ien = (paddr == `OFS_IRQ_ENABLE);
    wire mapped = hit_cnt | hit_cmp | hit_ctl | hit_ast | hit_flg | hit_ien;
    wire [2:0] reg_wr = {bus_wr & hit_cnt, bus_wr & hit_cmp,
                         bus_wr & hit_ctl};
    wire [7:0] wbyte = pwdata[7:0];

    // Changing the clock source aborts pending transfers; contents are
    // not guaranteed afterwards, so no attempt is made to keep them.
    wire as_change = bus_wr & hit_ast &
                     (pwdata[`AST_ASYNC_SEL_BIT] != async_clock_select_r);

    // ------------------------------------------------------------------
    // Timer clock
    // ------------------------------------------------------------------
    // Edges are ignored in power-down; nothing is rebuilt on wake. [R11]
    assign osc_rise = osc_rise_raw & ~power_down; // [R9]
    wire src_tick = async_clock_select_r ? osc_rise : 1'b1; // [R17]
    wire [2:0] cs = dest_r[IX_CTL][`CTL_CS_MSB:`CTL_CS_LSB];
    wire tick = src_tick & presc_hit(cs, pre_r);
    wire ctc = dest_r[IX_CTL][`CTL_CTC_BIT];
    wire [1:0] com = dest_r[IX_CTL][`CTL_COM_MSB:`CTL_COM_LSB];
    wire cmp_suppress = busy_r[IX_CNT] | busy_r[IX_CMP]; // [R4]
    wire [7:0] cnt_inc = timer_live_count_r + 8'h01;
    wire at_cmp = (timer_live_count_r == dest_r[IX_CMP]);
    wire [7:0] cnt_step = (ctc && at_cmp) ? 8'h00 : cnt_inc;
    wire ev_ovf = tick & (timer_live_count_r == 8'hff) & ~(ctc & at_cmp);
    wire ev_cmp = tick & ~cmp_suppress &
                  (cnt_step == dest_r[IX_CMP]) & ~(ctc & at_cmp);

    // Copy from holding register on the second oscillator edge.
    wire [2:0] xfer = busy_r & {3{osc_rise}} & edge_cnt_r; // [R1]

    // ------------------------------------------------------------------
    // Holding registers and transfer
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 3; i++) begin
                hold_r[i] <= `RST_BYTE;
                dest_r[i] <= `RST_BYTE;
            end
            busy_r <= 3'h0;
            edge_cnt_r <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin // [R2]
                if (reg_wr[i]) begin
                    hold_r[i] <= wbyte; // [R1]
                end
                if (reg_wr[i] && async_clock_select_r) begin
                    busy_r[i] <= 1'b1; // [R16]
                    edge_cnt_r[i] <= 1'b0;
                end else if (as_change || xfer[i]) begin
                    busy_r[i] <= 1'b0; // [R16] [R8]
                    edge_cnt_r[i] <= 1'b0;
                end else if (busy_r[i] && osc_rise) begin
                    edge_cnt_r[i] <= 1'b1;
                end
                if (reg_wr[i] && !async_clock_select_r) begin
                    dest_r[i] <= wbyte;
                end else if (xfer[i]) begin
                    dest_r[i] <= hold_r[i]; // [R1]
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Counter, prescaler and compare output
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_live_count_r <= `RST_BYTE;
            pre_r <= '0;
            compare_out_r <= 1'b0;
        end else begin
            if (src_tick) begin
                pre_r <= (cs == 3'h0) ? '0 : pre_r + 1'b1;
            end
            if (reg_wr[IX_CNT] && !async_clock_select_r) begin
                timer_live_count_r <= wbyte;
            end else if (xfer[IX_CNT]) begin
                timer_live_count_r <= hold_r[IX_CNT];
            end else if (tick) begin
                timer_live_count_r <= cnt_step;
            end
            // Driven on the timer tick itself, never through the flag
            // synchroniser, so the pin follows the timer clock.
            if (ev_cmp) begin // [R15]
                case (timer2_pkg::com_mode_t'(com))
                    timer2_pkg::COM_TOGGLE: compare_out_r <= ~compare_out_r;
                    timer2_pkg::COM_CLEAR: compare_out_r <= 1'b0;
                    timer2_pkg::COM_SET: compare_out_r <= 1'b1;
                    default: compare_out_r <= compare_out_r;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Flag synchronisation
    // ------------------------------------------------------------------
    // In async mode an event waits for the next oscillator edge, then
    // walks three pclk stages before it reaches the flag register.
    wire [1:0] ev_now = {ev_cmp, ev_ovf};
    wire [1:0] ev_launch = osc_rise ? ev_pend_r : 2'h0;
    wire [1:0] flag_set = async_clock_select_r ?
                          ev_stage_r[`FLAG_SYNC_PCLK-1] : ev_now; // [R14]
    wire [1:0] flag_clr = (bus_wr & hit_flg) ? wbyte[1:0] : 2'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_pend_r <= `RST_IRQ2;
            for (int s = 0; s < `FLAG_SYNC_PCLK; s++) begin
                ev_stage_r[s] <= `RST_IRQ2;
            end
            irq_flag_r <= `RST_IRQ2;
        end else begin
            if (!async_clock_select_r) begin
                ev_pend_r <= 2'h0;
            end else begin
                ev_pend_r <= (osc_rise ? 2'h0 : ev_pend_r) | ev_now; // [R14]
            end
            ev_stage_r[0] <= async_clock_select_r ? ev_launch : 2'h0;
            for (int s = 1; s < `FLAG_SYNC_PCLK; s++) begin
                ev_stage_r[s] <= ev_stage_r[s-1]; // [R14]
            end
            // A set in the same cycle as a write-one clear wins.
            irq_flag_r <= (irq_flag_r & ~flag_clr) | flag_set;
        end
    end

    // ------------------------------------------------------------------
    // Power-save wake-up
    // ------------------------------------------------------------------
    wire wake_cond = |(ev_now & irq_en_r);

    always_comb begin
        wake_nxt = wake_r;
        case (wake_r)
            timer2_pkg::WAKE_IDLE: begin
                if (power_save && armed_r && wake_cond) begin
                    wake_nxt = timer2_pkg::WAKE_PEND;
                end
            end
            timer2_pkg::WAKE_PEND: begin
                if (!power_save) begin
                    wake_nxt = timer2_pkg::WAKE_IDLE;
                end else if (osc_rise) begin
                    wake_nxt = timer2_pkg::WAKE_DONE; // [R12]
                end
            end
            timer2_pkg::WAKE_DONE: begin
                if (!power_save) begin
                    wake_nxt = timer2_pkg::WAKE_IDLE;
                end
            end
            default: wake_nxt = timer2_pkg::WAKE_IDLE;
        endcase
    end

    wire wake_start = (wake_r == timer2_pkg::WAKE_PEND) &&
                      (wake_nxt == timer2_pkg::WAKE_DONE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_r <= timer2_pkg::WAKE_IDLE;
            armed_r <= 1'b1;
            stall_cnt_r <= 3'h0;
        end else begin
            wake_r <= wake_nxt;
            // Interrupt logic rearms only after one full oscillator edge.
            if (wake_start) begin
                armed_r <= 1'b0; // [R5]
            end else if (osc_rise) begin
                armed_r <= 1'b1; // [R5]
            end
            if (wake_start) begin
                stall_cnt_r <= `WAKE_STALL_CYCLES; // [R13]
            end else if (stall_cnt_r != 3'h0) begin
                stall_cnt_r <= stall_cnt_r - 3'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Software-visible control and APB slave
    // ------------------------------------------------------------------
    wire [7:0] ast_val = {4'h0, async_clock_select_r, busy_r[IX_CNT],
                          busy_r[IX_CMP], busy_r[IX_CTL]};
    wire [31:0] rd_mux =
        hit_cnt ? byte_word(timer_live_count_r) : // [R18]
        hit_cmp ? byte_word(hold_r[IX_CMP]) : // [R18]
        hit_ctl ? byte_word(hold_r[IX_CTL]) :
        hit_ast ? byte_word(ast_val) :
        hit_flg ? {30'h0, irq_flag_r} :
        hit_ien ? {30'h0, irq_en_r} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            async_clock_select_r <= 1'b0;
            irq_en_r <= `RST_IRQ2;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            if (bus_wr && hit_ast) begin
                async_clock_select_r <= pwdata[`AST_ASYNC_SEL_BIT]; // [R17]
            end
            if (bus_wr && hit_ien) begin
                irq_en_r <= wbyte[1:0];
            end
            // One wait state: the answer comes one cycle into access.
            pready_r <= psel & penable & ~pready_r;
            pslverr_r <= psel & penable & ~pready_r & ~mapped;
            if (psel && penable && !pready_r && !pwrite) begin
                prdata_r <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
            osc_enable_r <= 1'b0;
            timer_wake_r <= 1'b0;
            cpu_stall_r <= 1'b0;
        end else begin
            irq_r <= |(((irq_flag_r & ~flag_clr) | flag_set) & irq_en_r);
            osc_enable_r <= async_clock_select_r & ~power_down; // [R9]
            timer_wake_r <= (wake_nxt == timer2_pkg::WAKE_DONE);
            cpu_stall_r <= wake_start || (stall_cnt_r > 3'h1); // [R13]
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign compare_out = compare_out_r;
    assign irq = irq_r;
    assign osc_enable = osc_enable_r;
    assign timer_wake = timer_wake_r;
    assign cpu_stall = cpu_stall_r;

endmodule // async_timer2_sync

// *** core/timer2_defs.svh ***
// Constants of the asynchronous timer block: register offsets, field
// positions, reset values and timing counts.
// Assumes inclusion by bare name from any design or bench file.
`ifndef TIMER2_DEFS_SVH
`define TIMER2_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the APB bus
// ----------------------------------------------------------------------
`define OFS_LIVE_COUNT 8'h00
`define OFS_COMPARE 8'h04
`define OFS_CONTROL 8'h08
`define OFS_ASYNC_STATUS 8'h0c
`define OFS_IRQ_FLAG 8'h10
`define OFS_IRQ_ENABLE 8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTL_CS_LSB 0
`define CTL_CS_MSB 2
`define CTL_CTC_BIT 3
`define CTL_COM_LSB 4
`define CTL_COM_MSB 5
`define AST_CTL_BUSY_BIT 0
`define AST_CMP_BUSY_BIT 1
`define AST_CNT_BUSY_BIT 2
`define AST_ASYNC_SEL_BIT 3
`define IRQ_OVF_BIT 0
`define IRQ_CMP_BIT 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_IRQ2 2'h0

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define XFER_OSC_EDGES 2
`define FLAG_SYNC_PCLK 3
`define WAKE_STALL_CYCLES 3'h4

`endif

// *** core/timer2_pkg.sv ***
// Types shared by the asynchronous timer block.
// Assumes nothing of its surroundings.
package timer2_pkg;

    typedef enum logic [2:0] {
        WAKE_IDLE = 3'b001,
        WAKE_PEND = 3'b010,
        WAKE_DONE = 3'b100
    } wake_state_t;

    typedef enum logic [1:0] {
        COM_NONE = 2'h0,
        COM_TOGGLE = 2'h1,
        COM_CLEAR = 2'h2,
        COM_SET = 2'h3
    } com_mode_t;

endpackage

// *** core/osc_edge_sync.sv ***
// Two-flop synchroniser for the timer oscillator input with rising-edge
// detection on the synchronised level.
// Assumes the input is asynchronous to pclk and much slower than it.
module osc_edge_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic rise
);

    logic meta_r;
    logic sync_r;
    logic last_r;

    // The first flop feeds only the second; edges are found downstream.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign rise = sync_r & ~last_r;

endmodule // osc_edge_sync

// *** tb/async_timer2_sync_assertions.sv ***
// Concurrent checks on the ports of the asynchronous timer block.
// Assumes a bind from the bench and a single pclk domain.
module async_timer2_sync_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timer_osc_input,
    input wire logic power_save,
    input wire logic power_down,
    input wire logic osc_enable,
    input wire logic irq,
    input wire logic timer_wake,
    input wire logic cpu_stall
);
    timeunit 1ns;
    timeprecision 1ps;

    // Cycles since the oscillator pin last rose, saturating at ff.
    logic osc_q_r;
    logic [7:0] osc_age_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_q_r <= 1'b0;
            osc_age_r <= 8'hff;
        end else begin
            osc_q_r <= timer_osc_input;
            if (timer_osc_input && !osc_q_r) begin
                osc_age_r <= 8'h00;
            end else if (osc_age_r != 8'hff) begin
                osc_age_r <= osc_age_r + 8'h01;
            end
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_pready_pulse;
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse)
        else $error("pready longer than one cycle");
    property p_upper_zero;
        pready && !pwrite |-> prdata[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("read data upper bits not zero");
    property p_err_zero;
        pready && pslverr && !pwrite |-> prdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero)
        else $error("refused read returned data");
    property p_stall_four;
        $rose(cpu_stall) |-> cpu_stall[*4] ##1 !cpu_stall;
    endproperty
    a_stall_four: assert property (p_stall_four)
        else $error("stall not four cycles");
    property p_wake_stall;
        $rose(timer_wake) |-> ##[0:2] cpu_stall;
    endproperty
    a_wake_stall: assert property (p_wake_stall)
        else $error("wake without stall");
    property p_wake_in_save;
        $rose(timer_wake) |-> $past(power_save);
    endproperty
    a_wake_in_save: assert property (p_wake_in_save)
        else $error("wake outside power save");
    property p_wake_osc;
        $rose(timer_wake) |-> osc_age_r <= 8'h07;
    endproperty
    a_wake_osc: assert property (p_wake_osc)
        else $error("wake not on an oscillator edge");
    property p_osc_down;
        power_down |=> !osc_enable;
    endproperty
    a_osc_down: assert property (p_osc_down)
        else $error("oscillator enabled in power down");

    c_wake: cover property ($rose(timer_wake));
    c_irq: cover property ($rose(irq));
    c_err: cover property (pready && pslverr);
endmodule // async_timer2_sync_assertions

// *** tb/timer_osc_model.sv ***
// Crystal oscillator model for the timer pin, 200 ns period.
// Assumes run follows the block's oscillator enable.
module timer_osc_model (
    input wire logic run,
    output logic osc
);
    timeunit 1ns;
    timeprecision 1ps;

    // The crystal stands low while it is stopped, as in power down.
    always begin
        osc = 1'b0;
        wait (run === 1'b1);
        // Edges land off the pclk edges, so sampling never races them.
        #3;
        while (run === 1'b1) begin
            #100 osc = 1'b1;
            #100 osc = 1'b0;
        end
    end
endmodule // timer_osc_model

// *** tb/async_timer2_sync_tb.sv ***
// Self-checking bench of the asynchronous timer block.
// Assumes the design under core/ and the oscillator model beside it.
`define CHK(nm, ex, gt) begin \
    samples_checked++; \
    if ((gt) !== (ex)) begin \
        fail_count++; \
        $display("[FAIL] %s exp=%0h got=%0h", nm, ex, gt); \
    end \
end

module async_timer2_sync_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] x;
        logic e;
    } row_t;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic power_save = 1'b0;
    logic power_down = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, osc, osc_enable, compare_out, irq;
    logic timer_wake, cpu_stall, e, co;
    logic [31:0] r;
    int fail_count = 0;
    int samples_checked = 0;
    int n;
    int s;
    time t0;
    row_t rows [8] = '{
        '{1'b1, 8'h04, 8'ha5, 8'h00, 1'b0}, '{1'b0, 8'h04, 8'h00, 8'ha5, 1'b0},
        '{1'b1, 8'h08, 8'h30, 8'h00, 1'b0}, '{1'b0, 8'h08, 8'h00, 8'h30, 1'b0},
        '{1'b0, 8'h0c, 8'h00, 8'h00, 1'b0}, '{1'b1, 8'h14, 8'h03, 8'h00, 1'b0},
        '{1'b0, 8'h14, 8'h00, 8'h03, 1'b0}, '{1'b0, 8'h20, 8'h00, 8'h00, 1'b1}
    };

    always #12.5 pclk = ~pclk;

    timer_osc_model u_osc (.run(osc_enable), .osc(osc));

    async_timer2_sync u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_osc_input(osc),
        .power_save(power_save), .power_down(power_down),
        .osc_enable(osc_enable), .compare_out(compare_out), .irq(irq),
        .timer_wake(timer_wake), .cpu_stall(cpu_stall)
    );

    // ------------------------------------------------------------------
    // Bus and closing tasks
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Ends when pready rises; only the watchdog ends it if pready never does.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        `CHK("pready", 1'b1, pready)
    endtask

    // Software must not rewrite a register until its transfer lands.
    task automatic wait_idle;
        int k;
        k = 0;
        do begin
            apb(1'b0, 8'h0c, 8'h00);
            k++;
        end while (r[2:0] !== 3'h0 && k < 100);
        `CHK("busy clear", 3'h0, r[2:0])
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #400us;
        fail_count++;
        $display("[FAIL] watchdog exp=done got=hang");
        test_done;
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        `CHK("idle", 5'h0, {pready, irq, timer_wake, cpu_stall, osc_enable})
        $display("test reset done");
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            `CHK("pslverr", rows[i].e, e)
            if (!rows[i].w) `CHK("rdata", {24'h0, rows[i].x}, r)
        end
        $display("test table done");
        apb(1'b1, 8'h14, 8'h00);
        apb(1'b1, 8'h0c, 8'h08);
        repeat (2) @(posedge pclk);
        `CHK("osc_enable", 1'b1, osc_enable)
        apb(1'b1, 8'h04, 8'h03);
        apb(1'b1, 8'h08, 8'h11);
        t0 = $time;
        apb(1'b0, 8'h0c, 8'h00);
        `CHK("busy pair", 8'h0b, r[7:0])
        apb(1'b0, 8'h04, 8'h00);
        `CHK("compare hold", 8'h03, r[7:0])
        wait_idle;
        `CHK("span", 1'b1, ($time - t0) >= 200 && ($time - t0) <= 900)
        apb(1'b1, 8'h00, 8'h00);
        wait_idle;
        apb(1'b1, 8'h10, 8'h03);
        co = compare_out;
        apb(1'b1, 8'h14, 8'h02);
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        `CHK("irq", 1'b1, irq)
        `CHK("compare pin", ~co, compare_out)
        apb(1'b0, 8'h10, 8'h00);
        `CHK("flags", 8'h02, r[7:0])
        apb(1'b1, 8'h14, 8'h00);
        repeat (2) @(posedge pclk);
        `CHK("masked irq", 1'b0, irq)
        apb(1'b1, 8'h10, 8'h02);
        apb(1'b0, 8'h10, 8'h00);
        `CHK("flags w1c", 8'h00, r[7:0])
        $display("test async done");
        apb(1'b1, 8'h14, 8'h02);
        power_save <= 1'b1;
        n = 0;
        s = 0;
        while (timer_wake !== 1'b1 && n < 2600) begin
            @(posedge pclk);
            n++;
            s += (cpu_stall === 1'b1);
        end
        `CHK("wake", 1'b1, timer_wake)
        repeat (8) begin
            @(posedge pclk);
            s += (cpu_stall === 1'b1);
        end
        `CHK("stall cycles", 4, s)
        power_save <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK("wake drop", 1'b0, timer_wake)
        apb(1'b1, 8'h10, 8'h03);
        $display("test wake done");
        power_down <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK("osc down", 1'b0, osc_enable)
        power_down <= 1'b0;
        repeat (3) @(posedge pclk); // the model needs no settle time
        `CHK("osc back", 1'b1, osc_enable)
        apb(1'b1, 8'h00, 8'h10);
        apb(1'b1, 8'h0c, 8'h00);
        apb(1'b0, 8'h0c, 8'h00);
        `CHK("switch abort", 8'h00, r[7:0])
        apb(1'b1, 8'h08, 8'h2b);
        apb(1'b1, 8'h04, 8'h02);
        apb(1'b1, 8'h00, 8'h00);
        repeat (200) @(posedge pclk);
        `CHK("pin clear", 1'b0, compare_out)
        apb(1'b0, 8'h00, 8'h00);
        `CHK("clear on match", 1'b1, r[7:0] <= 8'h02)
        apb(1'b1, 8'h08, 8'h3b);
        repeat (120) @(posedge pclk);
        `CHK("pin set", 1'b1, compare_out)
        $display("test switch done");
        test_done;
    end
endmodule // async_timer2_sync_tb

bind async_timer2_sync async_timer2_sync_assertions u_chk (
    .pclk(pclk), .presetn(presetn), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_osc_input(timer_osc_input),
    .power_save(power_save), .power_down(power_down),
    .osc_enable(osc_enable), .irq(irq), .timer_wake(timer_wake),
    .cpu_stall(cpu_stall)
);
